// ===== spio_pkg.sv
package spio_pkg;
   // register word offsets, byte addresses on the apb bus
   localparam logic [7:0] OFF_DIRECTION   = 8'h00;
   localparam logic [7:0] OFF_LATCH       = 8'h04;
   localparam logic [7:0] OFF_PIN_SAMPLE  = 8'h08;
   localparam logic [7:0] OFF_OPEN_DRAIN  = 8'h0C;
   localparam logic [7:0] OFF_ANALOG      = 8'h10;
   localparam logic [7:0] OFF_CHANGE_EN   = 8'h14;
   localparam logic [7:0] OFF_PULLUP      = 8'h18;
   localparam logic [7:0] OFF_PULLDOWN    = 8'h1C;
   localparam logic [7:0] OFF_SLEW_HIGH   = 8'h20;
   localparam logic [7:0] OFF_SLEW_LOW    = 8'h24;
   localparam logic [7:0] OFF_CHANGE_STAT = 8'h28;
   // reset values
   localparam logic [15:0] RST_DIRECTION  = 16'hFFFF;
   localparam logic [15:0] RST_ANALOG     = 16'h0FFF;
   localparam logic [15:0] RST_ZERO       = 16'h0000;
   // slew codes
   typedef enum logic [1:0] {
      SPIO_SLEW_FASTEST = 2'b00,
      SPIO_SLEW_X4      = 2'b01,
      SPIO_SLEW_X8      = 2'b10,
      SPIO_SLEW_X16     = 2'b11
   } spio_slew_t;
   // pad-side control bundle for one port
   typedef struct packed {
      logic [15:0] out_data;
      logic [15:0] out_en;
      logic [15:0] pull_up;
      logic [15:0] pull_down;
      logic [15:0] analog;
   } spio_pad_t;
   // peripheral ownership bundle
   typedef struct packed {
      logic [15:0] owns;
      logic [15:0] data;
      logic [15:0] oe;
   } spio_periph_t;
endpackage

// ===== spio_change_detect.sv
`timescale 1ns/10ps
// change detector: sticky flag per pin when the level differs from the last one
module spio_change_detect #(
   parameter int WIDTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] level,
   input  wire logic [WIDTH-1:0] enable,
   input  wire logic [WIDTH-1:0] clear,
   output logic      [WIDTH-1:0] pending
);
   logic [WIDTH-1:0] prev_r;   // previously captured level
   logic [WIDTH-1:0] seen;     // change seen this cycle on an enabled pin

   assign seen = (level ^ prev_r) & enable; // [R22] [R15] [R16]

   // capture the level every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= '0;
      end else begin
         prev_r <= level;
      end
   end

   // sticky pending, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending <= '0;
      end else begin
         pending <= (pending & ~clear) | seen; // [R22]
      end
   end
endmodule

// ===== spio_port.sv
`timescale 1ns/10ps
// Operation
// R1 - active peripheral owns pin output, still readable
// R2 - idle peripheral leaves pin to port
// R3 - port output never loops into peripheral
// R4 - direction bit one is input
// R5 - reset makes every pin input
// R6 - latch reads latch, sample reads pins
// R7 - unimplemented bits disabled, read zero, code resets analog select to RST_ANALOG without IMPL_MASK
// R8 - open drain only pulls low
// R9 - analog select resets to all ones, code resets it to RST_ANALOG, 16'h0FFF, pins 0 to 11 only
// R10 - software sets analog and direction together
// R11 - software clears analog before digital use
// R12 - output still driven while analog set
// R13 - analog inputs read zero in sample
// R14 - software waits one cycle before reading
// R15 - change on enabled pins raises request
// R16 - per pin change enable bit
// R17 - separate weak pull up, down enables
// R18 - software disables pulls on outputs
// R19 - two bit slew from two registers
// R20 - slew codes fastest, x4, x8, x16
// R21 - input only sharing keeps port control
// R22 - compare level, latch pending on difference
module spio_port #(
   parameter int          WIDTH     = 16,        // pins in this port
   parameter logic [15:0] IMPL_MASK = 16'hFFFF,  // implemented pins
   parameter logic [15:0] OUT_SHARE = 16'h0000   // pins with an output peripheral
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [WIDTH-1:0]     pin_in,
   output logic      [WIDTH-1:0]     pin_out,
   output logic      [WIDTH-1:0]     pin_oe,
   output spio_pkg::spio_pad_t       pad_ctl,
   output logic      [2*WIDTH-1:0]   pad_slew,
   input  spio_pkg::spio_periph_t    periph_ctl,
   output logic      [WIDTH-1:0]     periph_in,
   output logic                      change_irq
);
   logic [15:0] pin_direction_r;           // one means input
   logic [15:0] output_latch_r;            // port output data
   logic [15:0] open_drain_select_r;       // open drain per pin
   logic [15:0] analog_select_r;           // analog mode per pin
   logic [15:0] change_interrupt_enable_r; // change enables
   logic [15:0] weak_pullup_enable_r;      // pull-up enables
   logic [15:0] weak_pulldown_enable_r;    // pull-down enables
   logic [15:0] slew_select_high_r;        // slew code msb
   logic [15:0] slew_select_low_r;         // slew code lsb
   logic [15:0] pin_sync_r;                // sampled pin levels
   logic [15:0] pending;                   // sticky change flags
   logic [15:0] change_clear;              // clear pulse from software
   logic [15:0] own;                       // peripheral owns output
   logic [15:0] drv_data;                  // muxed output data
   logic [15:0] drv_en;                    // muxed output enable
   logic [15:0] pin_in_w;                  // pins widened to 16
   logic [15:0] rd_mux;                    // read data before flop
   logic        wr_en;                     // write commits
   logic        rd_en;                     // read commits
   logic        addr_ok;                   // mapped address

   // merge a 16-bit write under byte strobes, unimplemented bits stay zero
   function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r & IMPL_MASK; // [R7]
   endfunction

   // apb access phase decode, zero wait states
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign pin_in_w = 16'(pin_in);

   // address decode
   always_comb begin
      case (paddr)
         spio_pkg::OFF_DIRECTION, spio_pkg::OFF_LATCH, spio_pkg::OFF_PIN_SAMPLE,
         spio_pkg::OFF_OPEN_DRAIN, spio_pkg::OFF_ANALOG, spio_pkg::OFF_CHANGE_EN,
         spio_pkg::OFF_PULLUP, spio_pkg::OFF_PULLDOWN, spio_pkg::OFF_SLEW_HIGH,
         spio_pkg::OFF_SLEW_LOW, spio_pkg::OFF_CHANGE_STAT: begin
            addr_ok = 1'b1;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // direction register, all implemented pins inputs after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_direction_r <= spio_pkg::RST_DIRECTION & IMPL_MASK; // [R5] [R7]
      end else if (wr_en && paddr == spio_pkg::OFF_DIRECTION) begin
         pin_direction_r <= wr16(pin_direction_r, pwdata, pstrb);
      end
   end

   // output latch, written through either latch or sample offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_latch_r <= spio_pkg::RST_ZERO;
      end else if (wr_en && (paddr == spio_pkg::OFF_LATCH ||
                             paddr == spio_pkg::OFF_PIN_SAMPLE)) begin
         output_latch_r <= wr16(output_latch_r, pwdata, pstrb); // [R6]
      end
   end

   // open drain select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         open_drain_select_r <= spio_pkg::RST_ZERO;
      end else if (wr_en && paddr == spio_pkg::OFF_OPEN_DRAIN) begin
         open_drain_select_r <= wr16(open_drain_select_r, pwdata, pstrb);
      end
   end

   // analog select, pins 0 to 11 in analog mode after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_select_r <= spio_pkg::RST_ANALOG; // [R9]
      end else if (wr_en && paddr == spio_pkg::OFF_ANALOG) begin
         analog_select_r <= wr16(analog_select_r, pwdata, pstrb);
      end
   end

   // change interrupt enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         change_interrupt_enable_r <= spio_pkg::RST_ZERO;
      end else if (wr_en && paddr == spio_pkg::OFF_CHANGE_EN) begin
         change_interrupt_enable_r <= wr16(change_interrupt_enable_r, pwdata, pstrb); // [R16]
      end
   end

   // weak pull enables, one register each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         weak_pullup_enable_r   <= spio_pkg::RST_ZERO;
         weak_pulldown_enable_r <= spio_pkg::RST_ZERO;
      end else begin
         if (wr_en && paddr == spio_pkg::OFF_PULLUP) begin
            weak_pullup_enable_r <= wr16(weak_pullup_enable_r, pwdata, pstrb); // [R17]
         end
         if (wr_en && paddr == spio_pkg::OFF_PULLDOWN) begin
            weak_pulldown_enable_r <= wr16(weak_pulldown_enable_r, pwdata, pstrb); // [R17]
         end
      end
   end

   // slew code halves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slew_select_high_r <= spio_pkg::RST_ZERO;
         slew_select_low_r  <= spio_pkg::RST_ZERO;
      end else begin
         if (wr_en && paddr == spio_pkg::OFF_SLEW_HIGH) begin
            slew_select_high_r <= wr16(slew_select_high_r, pwdata, pstrb); // [R19]
         end
         if (wr_en && paddr == spio_pkg::OFF_SLEW_LOW) begin
            slew_select_low_r <= wr16(slew_select_low_r, pwdata, pstrb); // [R19]
         end
      end
   end

   // pin sample register, inputs treated as synchronous
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync_r <= spio_pkg::RST_ZERO;
      end else begin
         pin_sync_r <= pin_in_w & IMPL_MASK; // [R7]
      end
   end

   // output ownership: only output-capable sharing peripherals take the pin
   assign own = periph_ctl.owns & periph_ctl.oe & OUT_SHARE; // [R1] [R2] [R21]

   // output mux, open drain only drives while the data is low
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (own[i]) begin
            drv_data[i] = periph_ctl.data[i]; // [R1]
            drv_en[i]   = 1'b1;
         end else begin
            drv_data[i] = output_latch_r[i]; // [R2] [R12]
            drv_en[i]   = ~pin_direction_r[i]; // [R4]
         end
         if (open_drain_select_r[i]) begin
            drv_en[i]   = drv_en[i] & ~drv_data[i]; // [R8]
            drv_data[i] = 1'b0;
         end
      end
      drv_en = drv_en & IMPL_MASK; // [R7]
   end

   assign pin_out = drv_data[WIDTH-1:0];
   assign pin_oe  = drv_en[WIDTH-1:0];

   // peripheral input sees the pad unless the port itself drives the pin
   assign periph_in = (pin_in_w[WIDTH-1:0] & ~(drv_en[WIDTH-1:0] & ~own[WIDTH-1:0])); // [R3]

   // pad bundle
   assign pad_ctl.out_data  = drv_data;
   assign pad_ctl.out_en    = drv_en;
   assign pad_ctl.pull_up   = weak_pullup_enable_r; // [R17]
   assign pad_ctl.pull_down = weak_pulldown_enable_r; // [R17]
   assign pad_ctl.analog    = analog_select_r;

   // slew code per pin, high bit from one register and low from the other
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         pad_slew[2*i +: 2] = {slew_select_high_r[i], slew_select_low_r[i]}; // [R19] [R20]
      end
   end

   // change status cleared by writing ones to it
   assign change_clear = (wr_en && paddr == spio_pkg::OFF_CHANGE_STAT) ?
                         pwdata[15:0] : 16'h0000;

   // change detector on the sampled pin levels
   spio_change_detect #(
      .WIDTH (16)
   ) u_detect (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (pin_sync_r),
      .enable  (change_interrupt_enable_r),
      .clear   (change_clear),
      .pending (pending)
   );

   // request to the processor, a level while any flag stands
   assign change_irq = |pending; // [R15]

   // read mux
   always_comb begin
      case (paddr)
         spio_pkg::OFF_DIRECTION:   rd_mux = pin_direction_r;
         spio_pkg::OFF_LATCH:       rd_mux = output_latch_r; // [R6]
         spio_pkg::OFF_PIN_SAMPLE:  rd_mux = pin_sync_r &
                                            ~(analog_select_r & pin_direction_r); // [R13]
         spio_pkg::OFF_OPEN_DRAIN:  rd_mux = open_drain_select_r;
         spio_pkg::OFF_ANALOG:      rd_mux = analog_select_r;
         spio_pkg::OFF_CHANGE_EN:   rd_mux = change_interrupt_enable_r;
         spio_pkg::OFF_PULLUP:      rd_mux = weak_pullup_enable_r;
         spio_pkg::OFF_PULLDOWN:    rd_mux = weak_pulldown_enable_r;
         spio_pkg::OFF_SLEW_HIGH:   rd_mux = slew_select_high_r;
         spio_pkg::OFF_SLEW_LOW:    rd_mux = slew_select_low_r;
         spio_pkg::OFF_CHANGE_STAT: rd_mux = pending;
         default:                   rd_mux = 16'h0000;
      endcase
   end

   // read data comes from a flop, updated at setup so access phase sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {16'h0000, rd_mux};
      end
   end

   // assertions
   // setup cycle of a read of the pin sample register
   sequence s_sample_setup;
      psel && !penable && !pwrite && paddr == spio_pkg::OFF_PIN_SAMPLE;
   endsequence
   // an enabled pin whose sampled level moved since the last edge
   sequence s_enabled_change;
      ((pin_sync_r ^ $past(pin_sync_r)) & change_interrupt_enable_r) != 16'h0000;
   endsequence
   // one edge on, every enabled pin that moved holds its flag even under a clear
   sequence s_flag_for_change;
      (($past(pin_sync_r) ^ $past(pin_sync_r, 2)) & $past(change_interrupt_enable_r) &
       ~pending) == 16'h0000;
   endsequence

   // reset leaves every implemented pin an input
   a_reset_all_input: assert property (@(posedge pclk) // [R5]
      $rose(presetn) |-> pin_direction_r == (spio_pkg::RST_DIRECTION & IMPL_MASK))
      else $error("direction not all input after reset");
   // pins 0 to 11 in analog mode after reset
   a_analog_reset_ones: assert property (@(posedge pclk) // [R9]
      $rose(presetn) |-> analog_select_r == spio_pkg::RST_ANALOG)
      else $error("analog select reset value wrong");
   // an owning peripheral keeps the driver, open drain still applies
   a_periph_owns_pin: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      (own != 16'h0000) |-> ((drv_en & own) == (own & ~(open_drain_select_r &
      periph_ctl.data))))
      else $error("owning peripheral lost the driver");
   // input pins left to the port are never driven
   a_input_not_driven: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      ((pin_direction_r & ~own) != 16'h0000) |->
      ((drv_en & pin_direction_r & ~own) == 16'h0000))
      else $error("input pin driven by port");
   // open drain never drives high, nor drives a pin left to the port while the latch is high
   a_open_drain_low: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      ((drv_en & open_drain_select_r & (drv_data | (output_latch_r & ~own))) == 16'h0000))
      else $error("open drain pin driven high");
   // unimplemented direction, latch and sample bits stay zero
   a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      ((pin_direction_r | output_latch_r | pin_sync_r) & ~IMPL_MASK) == 16'h0000)
      else $error("unimplemented bit nonzero");
   // a write to the sample register lands in the latch
   a_latch_write: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (wr_en && paddr == spio_pkg::OFF_PIN_SAMPLE && pstrb[1:0] == 2'b11) |=>
      output_latch_r == ($past(pwdata[15:0]) & IMPL_MASK))
      else $error("pin sample write missed the latch");
   // an enabled change raises the request one edge later
   a_change_pending: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      s_enabled_change |=> change_irq)
      else $error("change not raised");
   // the flag of a changed pin is set, a clear in the same cycle loses
   a_change_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
      s_enabled_change |=> s_flag_for_change)
      else $error("change flag not latched");
   // slew code routing on pin 0
   a_slew_code: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
      pad_slew[1:0] == {slew_select_high_r[0], slew_select_low_r[0]})
      else $error("slew code routing wrong");
   // analog inputs read back low from the sample register
   a_sample_analog_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      s_sample_setup |=>
      (prdata[15:0] & $past(analog_select_r & pin_direction_r)) == 16'h0000)
      else $error("analog input read back high");
   // a pin the port drives never reaches the peripheral input
   a_loop_blocked: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (periph_in & drv_en[WIDTH-1:0] & ~own[WIDTH-1:0]) == '0)
      else $error("port output looped into peripheral input");
   // free push-pull pins follow latch and direction
   a_idle_port_drives: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (((drv_en ^ ~pin_direction_r) | (drv_data ^ output_latch_r)) & ~own &
       ~open_drain_select_r & IMPL_MASK) == 16'h0000)
      else $error("port does not drive a free pin");
endmodule

// ===== spio_pin_model.sv
`timescale 1ns/10ps
// pin side: resolves each pad from the port driver, an outside source and the weak pulls
module spio_pin_model #(
   parameter int WIDTH = 16  // pins modelled
) (
   input  wire logic             pclk,
   input  wire logic [WIDTH-1:0] pin_out,
   input  wire logic [WIDTH-1:0] pin_oe,
   input  wire logic [WIDTH-1:0] pull_up,
   input  wire logic [WIDTH-1:0] pull_down,
   input  wire logic [WIDTH-1:0] ext_val,
   input  wire logic [WIDTH-1:0] ext_en,
   output logic      [WIDTH-1:0] pin_in
);
   logic [WIDTH-1:0] float_r = '0;  // undriven pads wander so a stale level never looks valid
   // floating pattern flips every cycle
   always_ff @(posedge pclk) begin
      float_r <= ~float_r;
   end
   // pad resolution, the port driver wins over the outside source
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];  // open drain shows up only as enable with data low
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else if (pull_up[i]) begin
            pin_in[i] = 1'b1;  // weak pull-up
         end else if (pull_down[i]) begin
            pin_in[i] = 1'b0;  // weak pull-down
         end else begin
            pin_in[i] = float_r[i];
         end
      end
   end
endmodule

// ===== shared_pin_io_port_tb.sv
`timescale 1ns/10ps
// register, pad and change-request checks for one port
module shared_pin_io_port_tb;
   localparam logic [15:0] IMPL  = 16'h7FFF;  // top pin left unimplemented
   localparam logic [15:0] SHARE = 16'h00FF;  // low byte has output peripherals
   // one table row: write, then read back
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic        err;
   } spio_row_t;
   logic                   pclk = 1'b0;     // 100 MHz
   logic                   presetn = 1'b0;  // active low
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [7:0]             paddr = 8'h00;
   logic [31:0]            pwdata = 32'h0000_0000;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [15:0]            pin_in;
   logic [15:0]            pin_out;
   logic [15:0]            pin_oe;
   spio_pkg::spio_pad_t    pad_ctl;
   logic [31:0]            pad_slew;
   spio_pkg::spio_periph_t periph_ctl = '0;
   logic [15:0]            periph_in;
   logic                   change_irq;
   logic [15:0]            ext_val = 16'h0000;  // outside level on input pins
   logic [15:0]            ext_en = 16'hFF00;   // outside source on the high byte
   logic [31:0]            rd;                  // last read data
   logic                   err;                 // last slave error
   int                     num_errors = 0;
   int                     n_checks = 0;
   int                     cycles = 0;
   int                     n;
   spio_row_t              rows [10] = '{
      '{spio_pkg::OFF_DIRECTION, 16'hF234, 16'h7234, 1'b0},
      '{spio_pkg::OFF_LATCH, 16'hFFFF, 16'h7FFF, 1'b0},
      '{spio_pkg::OFF_OPEN_DRAIN, 16'h00F0, 16'h00F0, 1'b0},
      '{spio_pkg::OFF_ANALOG, 16'h0123, 16'h0123, 1'b0},
      '{spio_pkg::OFF_CHANGE_EN, 16'h0000, 16'h0000, 1'b0},
      '{spio_pkg::OFF_PULLUP, 16'h1000, 16'h1000, 1'b0},    // pulls on input pins only
      '{spio_pkg::OFF_PULLDOWN, 16'h2000, 16'h2000, 1'b0},
      '{spio_pkg::OFF_SLEW_HIGH, 16'h0055, 16'h0055, 1'b0},
      '{spio_pkg::OFF_SLEW_LOW, 16'h00AA, 16'h00AA, 1'b0},
      '{8'h3C, 16'h1234, 16'h0000, 1'b1}
   };
   // clock
   always #5 pclk = ~pclk;
   spio_port #(.WIDTH(16), .IMPL_MASK(IMPL), .OUT_SHARE(SHARE)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pad_ctl(pad_ctl), .pad_slew(pad_slew), .periph_ctl(periph_ctl),
      .periph_in(periph_in), .change_irq(change_irq));
   spio_pin_model #(.WIDTH(16)) pins (
      .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pad_ctl.pull_up),
      .pull_down(pad_ctl.pull_down), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
   // verdict and end of run
   task automatic final_report();
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one comparison
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // apb transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
      int w;
      w = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 16);
      if (w >= 16) begin
         num_errors++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
      apb(1'b0, a, 16'h0000);
      check(what, rd[15:0], exp);
   endtask
   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end
   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         wr16(rows[i].addr, rows[i].wdata);
         rd_chk("reg", rows[i].addr, rows[i].rdata);
         check("slverr", 16'(err), 16'(rows[i].err));
      end
      check("pull_up", pad_ctl.pull_up, 16'h1000);
      check("pull_down", pad_ctl.pull_down, 16'h2000);
      // second reset in mid-run
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("dir_rst", spio_pkg::OFF_DIRECTION, IMPL);
      rd_chk("an_rst", spio_pkg::OFF_ANALOG, spio_pkg::RST_ANALOG);
      rd_chk("lat_rst", spio_pkg::OFF_LATCH, spio_pkg::RST_ZERO);
      check("oe_rst", pin_oe, 16'h0000);
      // low byte as digital outputs
      wr16(spio_pkg::OFF_ANALOG, 16'h0000);  // digital use needs analog cleared
      wr16(spio_pkg::OFF_LATCH, 16'h00A5);
      wr16(spio_pkg::OFF_DIRECTION, 16'h7F00);
      repeat (3) @(posedge pclk);  // gap before reading back
      check("oe", pin_oe, 16'h00FF);
      check("pin_out", pin_out & 16'h00FF, 16'h00A5);
      check("loop", periph_in & 16'h00FF, 16'h0000);
      rd_chk("sample", spio_pkg::OFF_PIN_SAMPLE, 16'h00A5);
      wr16(spio_pkg::OFF_PIN_SAMPLE, 16'h005B);
      rd_chk("lat_w", spio_pkg::OFF_LATCH, 16'h005B);
      // open drain: pin 0 high releases, pin 2 low drives
      wr16(spio_pkg::OFF_OPEN_DRAIN, 16'h0005);
      repeat (2) @(posedge pclk);
      check("od_oe", pin_oe & 16'h0005, 16'h0004);
      check("od_out", pin_out & 16'h0004, 16'h0000);
      wr16(spio_pkg::OFF_OPEN_DRAIN, 16'h0000);
      // peripheral drives pin 0, is enabled but idle on pin 1, input-only on pin 8
      periph_ctl <= '{owns: 16'h0103, data: 16'h0100, oe: 16'h0101};
      repeat (3) @(posedge pclk);
      check("own_out", pin_out & 16'h0001, 16'h0000);
      check("own_oe", pin_oe & 16'h0103, 16'h0003);
      apb(1'b0, spio_pkg::OFF_PIN_SAMPLE, 16'h0000);
      check("own_read", rd[15:0] & 16'h0001, 16'h0000);
      periph_ctl <= '{owns: 16'h0000, data: 16'h0100, oe: 16'h0101};
      repeat (2) @(posedge pclk);
      check("idle_oe", pin_oe & 16'h0003, 16'h0003);
      check("idle_out", pin_out & 16'h0003, 16'h0003);
      // analog on output pin 7 and input pin 9
      wr16(spio_pkg::OFF_ANALOG, 16'h0280);  // analog input with direction set
      ext_val <= 16'h8200;  // pin 15 high too, it must still read zero
      repeat (3) @(posedge pclk);
      check("an_oe", pin_oe & 16'h0080, 16'h0080);
      check("pass", periph_in & 16'h0200, 16'h0200);
      rd_chk("an_read", spio_pkg::OFF_PIN_SAMPLE, 16'h005B);
      wr16(spio_pkg::OFF_ANALOG, 16'h0000);
      // every slew code on pin 0
      for (int k = 0; k < 4; k++) begin
         wr16(spio_pkg::OFF_SLEW_HIGH, 16'(k >> 1));
         wr16(spio_pkg::OFF_SLEW_LOW, 16'(k & 1));
         repeat (2) @(posedge pclk);
         check("slew", 16'(pad_slew[1:0]), 16'(k));
      end
      // change request on pin 10 only
      wr16(spio_pkg::OFF_CHANGE_EN, 16'h0400);
      wr16(spio_pkg::OFF_CHANGE_STAT, 16'hFFFF);
      repeat (3) @(posedge pclk);
      check("irq_idle", 16'(change_irq), 16'h0000);
      ext_val <= 16'h0C00;
      n = 0;
      while (change_irq !== 1'b1 && n < 10) begin
         @(posedge pclk);
         n++;
      end
      check("irq_set", 16'(change_irq), 16'h0001);
      rd_chk("stat", spio_pkg::OFF_CHANGE_STAT, 16'h0400);
      wr16(spio_pkg::OFF_CHANGE_STAT, 16'h0400);
      repeat (2) @(posedge pclk);
      check("irq_clr", 16'(change_irq), 16'h0000);
      final_report();
   end
endmodule
